//--- lts_map.vh
`ifndef LTS_MAP_VH
`define LTS_MAP_VH

// ---------------------------------------------------------------------
// timing (clock 20 MHz, 50 ns)
// ---------------------------------------------------------------------
`define LTS_CLK_PERIOD_NS 50
`define LTS_DOM_TX_TIME_US 20000
`define LTS_PERM_REC_TIME_US 40
`define LTS_DOM_BUS_TIME_US 20000
`define LTS_WAKE_PATTERN_TIME_US 150
`define LTS_GLITCH_TIME_US 28
`define LTS_BUS_WAKE_TIME_US 150
// least times round up to whole cycles
`define LTS_US_TO_CYC_UP(t) (((t) * 1000 + `LTS_CLK_PERIOD_NS - 1) / `LTS_CLK_PERIOD_NS)
`define LTS_DOM_TX_CYC `LTS_US_TO_CYC_UP(`LTS_DOM_TX_TIME_US)
`define LTS_PERM_REC_CYC `LTS_US_TO_CYC_UP(`LTS_PERM_REC_TIME_US)
`define LTS_DOM_BUS_CYC `LTS_US_TO_CYC_UP(`LTS_DOM_BUS_TIME_US)
`define LTS_WAKE_PATTERN_CYC `LTS_US_TO_CYC_UP(`LTS_WAKE_PATTERN_TIME_US)
`define LTS_GLITCH_CYC `LTS_US_TO_CYC_UP(`LTS_GLITCH_TIME_US)
`define LTS_BUS_WAKE_CYC `LTS_US_TO_CYC_UP(`LTS_BUS_WAKE_TIME_US)

// ---------------------------------------------------------------------
// field positions of the status word
// ---------------------------------------------------------------------
`define LTS_ST_TXDOM 0
`define LTS_ST_PREC 1
`define LTS_ST_PDOM 2
`define LTS_ST_WIDTH 3

// ---------------------------------------------------------------------
// fifo defaults and wake-up type select codes
// ---------------------------------------------------------------------
`define LTS_FIFO_WIDTH 1
`define LTS_FIFO_DEPTH 16
`define LTS_WU_PATTERN 1'b0
`define LTS_WU_STATE 1'b1

`endif

//--- lts_fifo_mem.v
`timescale 1ns/1ps
// small storage array with registered read data
module lts_fifo_mem #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock
    input wire clk,
    // write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    // read side
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // write port and registered read port
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

//--- lts_fifo.v
`timescale 1ns/1ps
// synchronous fifo, valid/ready on both sides, show-ahead output
module lts_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [AW:0] count_reg;
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    wire push;
    wire pop;
    wire load;
    wire [AW-1:0] rptr_next;
    wire mem_avail;

    // the memory word count excludes the word held at the output
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign push = in_valid & in_ready;
    assign mem_avail = (count_reg != {(AW+1){1'b0}});
    assign load = mem_avail & (~out_valid | out_ready);
    assign pop = out_valid & out_ready;
    assign rptr_next = load ? rptr_reg + 1'b1 : rptr_reg;

    // pointers, count and output valid
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {(AW+1){1'b0}};
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            rptr_reg <= rptr_next;
            count_reg <= count_reg + {{AW{1'b0}}, push}
                - {{AW{1'b0}}, load};
            if (load) begin
                out_valid <= 1'b1;
            end else if (pop) begin
                out_valid <= 1'b0;
            end
        end
    end

    lts_fifo_mem #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .clk(clk),
        .wr_en(push),
        .wr_addr(wptr_reg),
        .wr_data(in_data),
        .rd_addr(load ? rptr_reg : rptr_reg - 1'b1),
        .rd_data(out_data)
    );
endmodule

//--- lts_supervisor.v
`timescale 1ns/1ps
`include "lts_map.vh"
// Contract
// - transceiver enabled right after supply power-on reset, no command needed
// - transmitter off on timeout, perm recessive, thermal, supply or v1 fault
// - thermal level1 from global sensor, or cluster four sensor when clustered
// - receiver never disabled by faults; reactivated after thermal fail-safe
// - tx input dominant past timeout disables transmitter, sets timeout flag
// - latched tx disables hold until software clears the matching flag
// - timeout enable low turns off dominant timeout detection
// - tx dominant without rx following in time disables tx, sets flag
// - bus dominant too long sets permanent dominant flag, tx stays on
// - standby accepts lin wake-up, pattern or state change, pattern default
// - recessive-dominant-recessive with dominant at least 28 us glitch time wakes device
// - dominant pulses under 28 us glitch time never cause wake-up
// - state mode, entered recessive: dominant held wake time wakes device
// - state mode, entered dominant: recessive held wake time wakes device
// - supply over/undervoltage tristates lin output, receiver keeps working
module lts_supervisor #(
    parameter DOM_TX_CYC = `LTS_DOM_TX_CYC,
    parameter DOM_BUS_CYC = `LTS_DOM_BUS_CYC,
    parameter CW = 20,
    parameter FIFO_DEPTH = `LTS_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    // clock and reset (reset is the supply power-on reset)
    input wire clk,
    input wire rst_n,
    // protocol controller side
    input wire txd_in,
    input wire txd_valid,
    output wire txd_ready,
    output reg rxd_out,
    // lin bus pin
    input wire lin_in,
    output reg lin_out,
    output reg lin_oe,
    // fault inputs
    input wire thermal_shutdown_level1,
    input wire global_sensor_thermal_shutdown_level1,
    input wire cluster_four_sensor,
    input wire cluster_mode,
    input wire thermal_fail_safe,
    input wire regulator_supply_ov,
    input wire regulator_supply_uv,
    input wire v1_uv,
    // control
    input wire tx_timeout_detect_enable,
    input wire wakeup_type_select,
    input wire standby_mode,
    input wire clear_tx_dominant_timeout,
    input wire clear_permanent_recessive,
    input wire clear_permanent_dominant,
    // status
    output reg tx_dominant_timeout_flag,
    output reg permanent_recessive_flag,
    output reg permanent_dominant_flag,
    output reg tx_enabled,
    output reg rx_enabled,
    output reg wakeup_pulse
);
    // ---------------------------------------------------------------------
    // constants and state
    // ---------------------------------------------------------------------
    localparam [CW-1:0] PREC_LIM = `LTS_PERM_REC_CYC;
    localparam [CW-1:0] GLITCH_LIM = `LTS_GLITCH_CYC;
    localparam [CW-1:0] PAT_LIM = `LTS_WAKE_PATTERN_CYC;
    localparam [CW-1:0] BUSWU_LIM = `LTS_BUS_WAKE_CYC;
    localparam [CW-1:0] DTX_LIM = DOM_TX_CYC;
    localparam [CW-1:0] DBUS_LIM = DOM_BUS_CYC;

    localparam [1:0] WU_IDLE = 2'b00;
    localparam [1:0] WU_ARMED = 2'b01;
    localparam [1:0] WU_DOM = 2'b10;
    localparam [1:0] WU_SEEN = 2'b11;

    // saturating counter step: count while cond, else clear
    function [CW-1:0] cnt_step;
        input cond;
        input [CW-1:0] cur;
        begin
            if (!cond) begin
                cnt_step = {CW{1'b0}};
            end else if (cur == {CW{1'b1}}) begin
                cnt_step = cur;
            end else begin
                cnt_step = cur + 1'b1;
            end
        end
    endfunction

    reg [CW-1:0] txdom_cnt_reg;
    reg [CW-1:0] prec_cnt_reg;
    reg [CW-1:0] busdom_cnt_reg;
    reg [CW-1:0] wu_cnt_reg;
    reg [1:0] wu_state_reg;
    reg [1:0] wu_state_next;
    reg entry_level_reg;
    reg standby_d_reg;
    reg tx_bit_reg;
    reg prec_wait_reg;
    reg tx_prev_reg;
    wire fifo_valid;
    wire fifo_data;
    wire thermal_shutdown_level1_sel;
    wire supply_fault;
    wire tx_block;
    wire tx_dom;
    wire bus_dom;
    wire txdom_hit;
    wire prec_hit;
    wire busdom_hit;

    // ---------------------------------------------------------------------
    // transmit data path through the fifo
    // ---------------------------------------------------------------------
    lts_fifo #(
        .WIDTH(`LTS_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(txd_valid),
        .in_ready(txd_ready),
        .in_data(txd_in),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );

    // hold last bit while drained; recessive after reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_bit_reg <= 1'b1;
        end else if (fifo_valid) begin
            tx_bit_reg <= fifo_data;
        end
    end

    // ---------------------------------------------------------------------
    // fault decode
    // ---------------------------------------------------------------------
    assign thermal_shutdown_level1_sel = (cluster_mode ? cluster_four_sensor
        : global_sensor_thermal_shutdown_level1) | thermal_shutdown_level1;
    assign supply_fault = regulator_supply_ov | regulator_supply_uv;
    assign tx_block = tx_dominant_timeout_flag | permanent_recessive_flag
        | thermal_shutdown_level1_sel | supply_fault | v1_uv | standby_mode;
    assign tx_dom = ~tx_bit_reg;
    assign bus_dom = ~lin_in;
    // no transmitter-enable term here: a cleared flag must set again
    // while the dominant input is still standing
    assign txdom_hit = tx_timeout_detect_enable
        & (txdom_cnt_reg >= DTX_LIM);
    assign prec_hit = prec_wait_reg & (prec_cnt_reg >= PREC_LIM);
    assign busdom_hit = busdom_cnt_reg >= DBUS_LIM;

    // ---------------------------------------------------------------------
    // fault timers
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txdom_cnt_reg <= {CW{1'b0}};
            prec_cnt_reg <= {CW{1'b0}};
            busdom_cnt_reg <= {CW{1'b0}};
            prec_wait_reg <= 1'b0;
            tx_prev_reg <= 1'b1;
        end else begin
            tx_prev_reg <= tx_bit_reg;
            txdom_cnt_reg <= cnt_step(tx_dom & tx_timeout_detect_enable,
                txdom_cnt_reg);
            busdom_cnt_reg <= cnt_step(bus_dom, busdom_cnt_reg);
            // arm on tx falling edge, disarm when rx follows
            if (tx_prev_reg & ~tx_bit_reg & tx_enabled) begin
                prec_wait_reg <= 1'b1;
            end else if (bus_dom | ~tx_dom) begin
                prec_wait_reg <= 1'b0;
            end
            prec_cnt_reg <= cnt_step(prec_wait_reg & ~bus_dom,
                prec_cnt_reg);
        end
    end

    // ---------------------------------------------------------------------
    // latched status flags, set wins over clear
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_dominant_timeout_flag <= 1'b0;
            permanent_recessive_flag <= 1'b0;
            permanent_dominant_flag <= 1'b0;
        end else begin
            if (txdom_hit) begin
                tx_dominant_timeout_flag <= 1'b1;
            end else if (clear_tx_dominant_timeout) begin
                tx_dominant_timeout_flag <= 1'b0;
            end
            if (prec_hit) begin
                permanent_recessive_flag <= 1'b1;
            end else if (clear_permanent_recessive) begin
                permanent_recessive_flag <= 1'b0;
            end
            if (busdom_hit) begin
                permanent_dominant_flag <= 1'b1;
            end else if (clear_permanent_dominant) begin
                permanent_dominant_flag <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------------
    // transmitter, receiver and pin drive
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_enabled <= 1'b0;
            rx_enabled <= 1'b0;
            lin_out <= 1'b0;
            lin_oe <= 1'b0;
            rxd_out <= 1'b1;
        end else begin
            tx_enabled <= ~tx_block;
            // receiver stays on, back on after thermal fail-safe
            rx_enabled <= 1'b1 | thermal_fail_safe;
            // open drain: drive low only while dominant
            lin_out <= 1'b0;
            lin_oe <= ~tx_block & tx_dom & ~supply_fault;
            rxd_out <= lin_in;
        end
    end

    // ---------------------------------------------------------------------
    // wake-up decoder
    // ---------------------------------------------------------------------
    always @* begin
        wu_state_next = wu_state_reg;
        case (wu_state_reg)
            WU_IDLE: begin
                if (standby_mode & ~standby_d_reg) begin
                    wu_state_next = WU_ARMED;
                end
            end
            WU_ARMED: begin
                if (wakeup_type_select == `LTS_WU_PATTERN) begin
                    if (bus_dom) begin
                        wu_state_next = WU_DOM;
                    end
                end else if (wu_cnt_reg >= BUSWU_LIM) begin
                    wu_state_next = WU_SEEN;
                end
            end
            WU_DOM: begin
                if (!bus_dom) begin
                    // dominant at least glitch time is a valid pattern
                    if (wu_cnt_reg >= GLITCH_LIM) begin
                        wu_state_next = WU_SEEN;
                    end else begin
                        wu_state_next = WU_ARMED;
                    end
                end
            end
            WU_SEEN: begin
                wu_state_next = WU_IDLE;
            end
            default: begin
                wu_state_next = WU_IDLE;
            end
        endcase
        if (!standby_mode) begin
            wu_state_next = WU_IDLE;
        end
    end

    // wake state, entry level capture and timer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wu_state_reg <= WU_IDLE;
            wu_cnt_reg <= {CW{1'b0}};
            entry_level_reg <= 1'b1;
            standby_d_reg <= 1'b0;
            wakeup_pulse <= 1'b0;
        end else begin
            standby_d_reg <= standby_mode;
            wu_state_reg <= wu_state_next;
            if (standby_mode & ~standby_d_reg) begin
                entry_level_reg <= lin_in;
            end
            if (wu_state_reg == WU_DOM) begin
                wu_cnt_reg <= cnt_step(bus_dom, wu_cnt_reg);
            end else if (wu_state_reg == WU_ARMED) begin
                // state mode counts the level opposite to entry
                wu_cnt_reg <= cnt_step(wakeup_type_select
                    & (lin_in != entry_level_reg), wu_cnt_reg);
            end else begin
                wu_cnt_reg <= {CW{1'b0}};
            end
            wakeup_pulse <= (wu_state_next == WU_SEEN);
        end
    end
endmodule

//--- lts_bus_model.sv
`timescale 1ns/1ps
// lin bus with pull-up, transceiver pin and stuck-fault switches
module lts_bus_model (
    // transceiver pin
    input wire lin_out,
    input wire lin_oe,
    // fault injection from the bench
    input wire stuck_dom,
    input wire stuck_rec,
    // resolved bus level
    output wire lin_in
);
    // stuck dominant wins over all; stuck recessive overrides the pin; released bus pulls up
    assign lin_in = stuck_dom ? 1'b0 :
        (stuck_rec ? 1'b1 : (lin_oe ? lin_out : 1'b1));
endmodule

//--- lts_supervisor_props.sv
`timescale 1ns/1ps
// watches the supervisor status outputs against their causes
module lts_supervisor_props (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // observed ports
    input wire lin_oe,
    input wire tx_enabled,
    input wire rx_enabled,
    input wire tx_dominant_timeout_flag,
    input wire permanent_recessive_flag,
    input wire permanent_dominant_flag,
    input wire clear_tx_dominant_timeout,
    input wire clear_permanent_recessive,
    input wire tx_timeout_detect_enable,
    input wire regulator_supply_ov,
    input wire regulator_supply_uv,
    input wire v1_uv,
    input wire standby_mode,
    input wire wakeup_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rx_stays_on: assert property ($past(rst_n) |-> rx_enabled)
        else $error("receiver found disabled");
    a_supply_pin_off: assert property ((regulator_supply_ov ||
        regulator_supply_uv) [*4] |-> !lin_oe && !tx_enabled)
        else $error("lin pin driven during supply fault");
    a_v1_tx_off: assert property (v1_uv [*4] |-> !tx_enabled)
        else $error("transmitter on during v1 undervoltage");
    a_pdom_keeps_tx: assert property ($rose(permanent_dominant_flag)
        |-> $stable(tx_enabled))
        else $error("permanent dominant changed transmitter");
    a_tout_sticky: assert property ($fell(tx_dominant_timeout_flag)
        |-> $past(clear_tx_dominant_timeout))
        else $error("timeout flag dropped without clear");
    a_prec_sticky: assert property ($fell(permanent_recessive_flag)
        |-> $past(clear_permanent_recessive))
        else $error("recessive flag dropped without clear");
    a_tout_disabled: assert property (!tx_timeout_detect_enable [*3]
        ##0 !tx_dominant_timeout_flag |=> !tx_dominant_timeout_flag)
        else $error("timeout flagged while detection off");
    a_tout_tx_off: assert property (tx_dominant_timeout_flag
        |=> !tx_enabled)
        else $error("transmitter on after timeout");
    a_prec_tx_off: assert property (permanent_recessive_flag
        |=> !tx_enabled)
        else $error("transmitter on after permanent recessive");
    a_wake_in_stby: assert property (wakeup_pulse |-> standby_mode)
        else $error("wake pulse outside standby");
endmodule
bind lts_supervisor lts_supervisor_props u_props (
    .clk(clk), .rst_n(rst_n), .lin_oe(lin_oe), .tx_enabled(tx_enabled),
    .rx_enabled(rx_enabled),
    .tx_dominant_timeout_flag(tx_dominant_timeout_flag),
    .permanent_recessive_flag(permanent_recessive_flag),
    .permanent_dominant_flag(permanent_dominant_flag),
    .clear_tx_dominant_timeout(clear_tx_dominant_timeout),
    .clear_permanent_recessive(clear_permanent_recessive),
    .tx_timeout_detect_enable(tx_timeout_detect_enable),
    .regulator_supply_ov(regulator_supply_ov),
    .regulator_supply_uv(regulator_supply_uv), .v1_uv(v1_uv),
    .standby_mode(standby_mode), .wakeup_pulse(wakeup_pulse));

//--- tb_lin_transceiver_supervisor.sv
`timescale 1ns/1ps
module tb_lin_transceiver_supervisor;
    reg clk = 0, rst_n = 0, txd_in = 1, txd_valid = 1;
    reg stuck_dom = 0, stuck_rec = 0, tout_en = 1, wsel = 0, stby = 0;
    reg [7:0] flt = 8'h00;
    reg [2:0] clr = 3'h0;
    wire txd_ready, rxd_out, lin_in, lin_out, lin_oe, f_tout, f_prec, f_pdom;
    wire tx_en, rx_en, wp;
    integer err_count = 0, n_checks = 0, wake_count = 0, i;
    logic [8:0] tab [9] = '{9'h180, 9'h140, 9'h151, 9'h121, 9'h130,
        9'h109, 9'h104, 9'h102, 9'h101};
    // ----------------------------------------------------------------
    // clock, bus and design
    // ----------------------------------------------------------------
    always #25 clk = ~clk;
    lts_bus_model BUS (.lin_out(lin_out), .lin_oe(lin_oe),
        .stuck_dom(stuck_dom), .stuck_rec(stuck_rec), .lin_in(lin_in));
    lts_supervisor #(.DOM_TX_CYC(50), .DOM_BUS_CYC(200)) DUT (
        .clk(clk), .rst_n(rst_n), .txd_in(txd_in), .txd_valid(txd_valid),
        .txd_ready(txd_ready), .rxd_out(rxd_out), .lin_in(lin_in),
        .lin_out(lin_out), .lin_oe(lin_oe),
        .thermal_shutdown_level1(flt[7]), .global_sensor_thermal_shutdown_level1(flt[6]),
        .cluster_four_sensor(flt[5]), .cluster_mode(flt[4]),
        .thermal_fail_safe(flt[3]), .regulator_supply_ov(flt[2]),
        .regulator_supply_uv(flt[1]), .v1_uv(flt[0]),
        .tx_timeout_detect_enable(tout_en), .wakeup_type_select(wsel),
        .standby_mode(stby), .clear_tx_dominant_timeout(clr[0]),
        .clear_permanent_recessive(clr[1]), .clear_permanent_dominant(clr[2]),
        .tx_dominant_timeout_flag(f_tout), .permanent_recessive_flag(f_prec),
        .permanent_dominant_flag(f_pdom), .tx_enabled(tx_en),
        .rx_enabled(rx_en), .wakeup_pulse(wp));
    // counts wake pulses
    always @(posedge clk) if (wp === 1'b1) wake_count <= wake_count + 1;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // holds the transmit stream at one level
    task tx_level(input logic v, input integer n);
        @(posedge clk) txd_in <= v;
        cyc(n);
    endtask
    // one-cycle clear pulse on all flags, then a three-cycle wait
    task clear_all;
        @(posedge clk) clr <= 3'h7;
        @(posedge clk) clr <= 3'h0;
        cyc(3);
    endtask
    task wait_wake(input integer lim);
        integer c, k;
        c = wake_count;
        for (k = 0; k < lim && wake_count == c; k++) @(posedge clk);
        check(wake_count > c, 1);
        if (wake_count == c) results;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_timeout;
        tx_level(0, 70);
        check({f_tout, tx_en, f_pdom}, 3'b100);
        clear_all;
        check(f_tout, 1);
        tx_level(1, 10);
        clear_all;
        check({f_tout, tx_en}, 2'b01);
    endtask
    task t_tout_off;
        @(posedge clk) tout_en <= 0;
        tx_level(0, 100);
        check({f_tout, tx_en, lin_oe}, 3'b011);
        tx_level(1, 10);
    endtask
    task t_prec;
        @(posedge clk) stuck_rec <= 1;
        tx_level(0, 850);
        check({f_prec, tx_en}, 2'b10);
        tx_level(1, 5);
        @(posedge clk) stuck_rec <= 0;
        clear_all;
        check({f_prec, tx_en}, 2'b01);
        @(posedge clk) tout_en <= 1;
    endtask
    task t_pdom;
        @(posedge clk) stuck_dom <= 1;
        cyc(250);
        check({f_pdom, tx_en, rxd_out}, 3'b110);
        @(posedge clk) stuck_dom <= 0;
        clear_all;
        check(f_pdom, 0);
    endtask
    task t_faults;
        for (i = 0; i < 9; i++) begin
            @(posedge clk) flt <= {tab[i][7:1], 1'b0};
            tx_level(0, 6);
            check({tx_en, rx_en, lin_oe}, {tab[i][0], 1'b1, tab[i][0]});
            @(posedge clk) flt <= 8'h00;
            tx_level(1, 6);
        end
        @(posedge clk) flt <= 8'h01;
        tx_level(0, 6);
        check({tx_en, rx_en, lin_oe}, 3'b010);
        @(posedge clk) flt <= 8'h00;
        tx_level(1, 6);
    endtask
    task t_wake;
        @(posedge clk) stby <= 1;
        cyc(5);
        @(posedge clk) stuck_dom <= 1;
        cyc(300);
        @(posedge clk) stuck_dom <= 0;
        cyc(20);
        check(wake_count, 0);
        @(posedge clk) stuck_dom <= 1;
        cyc(3000);
        @(posedge clk) stuck_dom <= 0;
        wait_wake(20);
        @(posedge clk) stby <= 0;
    endtask
    task t_state;
        @(posedge clk) wsel <= 1;
        @(posedge clk) stby <= 1;
        cyc(5);
        @(posedge clk) stuck_dom <= 1;
        wait_wake(3100);
        @(posedge clk) stby <= 0;
        cyc(3);
        @(posedge clk) stby <= 1;
        cyc(5);
        @(posedge clk) stuck_dom <= 0;
        wait_wake(3100);
        @(posedge clk) stby <= 0;
        wsel <= 0;
        clear_all;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(6);
        @(posedge clk) rst_n <= 1;
        cyc(3);
        check({tx_en, rx_en, f_tout, f_prec, f_pdom}, 5'h18);
        t_timeout;
        t_tout_off;
        t_prec;
        t_pdom;
        t_faults;
        t_wake;
        t_state;
        results;
    end
endmodule
